// [common/mcr_consts.svh]
// register codes, field positions, reset values and sizes of the memory-control registers
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// register codes carried in the low eight address bits
`define MCR_CODE_MAP_UPPER    8'h01
`define MCR_CODE_MAP_LOWER    8'h02
`define MCR_CODE_MAP_VALID    8'h03
`define MCR_CODE_ERRST_UPPER  8'h10
`define MCR_CODE_ERRST_LOWER  8'h11
`define MCR_CODE_ERRADR_UPPER 8'h12
`define MCR_CODE_ERRADR_LOWER 8'h13
`define MCR_CODE_SBE_UPPER    8'h14
`define MCR_CODE_SBE_LOWER    8'h15
`define MCR_CODE_SLOT         8'h16
`define MCR_CODE_LOCK         8'h17
`define MCR_CODE_INT_BASE     8'h20
`define MCR_CODE_INT_LAST     8'h26

// address fields
`define MCR_CODE_MSB      7
`define MCR_CODE_LSB      0
`define MCR_VPN_LSB       8
`define MCR_IDX_W         6
`define MCR_ENTRIES       64

// translation half-word fields
`define MCR_HALF_W        16
`define MCR_PPN_MSB       15
`define MCR_PPN_LSB       4
`define MCR_FLAG_MSB      3

// error status bits
`define MCR_ST_ECC_BIT    0
`define MCR_ST_ACK_BIT    1

// counters and interrupt levels
`define MCR_SBE_W         16
`define MCR_INT_LEVELS    7
`define MCR_INT_W         8
`define MCR_SBE_INT_LVL   0
`define MCR_SBE_INT_LOWER 0
`define MCR_SBE_INT_UPPER 1
`define MCR_SLOT_W        4

// reset values
`define MCR_RST_WORD      32'h0000_0000
`define MCR_RST_HALF      16'h0000
`define MCR_RST_INT       8'h00

`endif

// [common/mcr_pkg.sv]
// types shared by the memory-control register files
`include "mcr_consts.svh"
package mcr_pkg;
    // one control-register instruction issued by the processor
    typedef struct packed {
        logic        rd;     // control_register_read
        logic        wr;     // control_register_write
        logic [31:0] addr;   // computed virtual address
        logic [31:0] wdata;  // data to write
    } mcr_cr_req_t;

    // error events reported by one half of the system_bus
    typedef struct packed {
        logic ack_err;     // acknowledge error
        logic ecc_uncorr;  // uncorrectable ecc error
        logic single_bit;  // corrected single-bit error
    } mcr_err_t;

    // which source feeds the read answer
    typedef enum logic [1:0] {
        MCR_SRC_REG,
        MCR_SRC_MAP_UPPER,
        MCR_SRC_MAP_LOWER
    } mcr_src_t;
endpackage

// [rtl/mcr_map_mem.sv]
// translation entry storage: two half-words per entry, registered read
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.svh"
module mcr_map_mem (
    input  wire logic                    mclk_i,      // processor clock
    input  wire logic                    rst_i,       // sync reset, high
    input  wire logic [`MCR_IDX_W-1:0]   idx_i,       // entry index
    input  wire logic                    we_upper_i,  // write upper half
    input  wire logic                    we_lower_i,  // write lower half
    input  wire logic [`MCR_HALF_W-1:0]  wdata_i,     // half-word to write
    input  wire logic                    re_i,        // read both halves
    output logic      [`MCR_HALF_W-1:0]  upper_o,     // upper half read
    output logic      [`MCR_HALF_W-1:0]  lower_o      // lower half read
);
    logic [`MCR_HALF_W-1:0] upper_mem [`MCR_ENTRIES];
    logic [`MCR_HALF_W-1:0] lower_mem [`MCR_ENTRIES];

    // array has no reset; software validates an entry by writing it
    always_ff @(posedge mclk_i) begin
        if (we_upper_i) begin
            upper_mem[idx_i] <= wdata_i;
        end
        if (we_lower_i) begin
            lower_mem[idx_i] <= wdata_i;
        end
    end

    // read data come out of a register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            upper_o <= `MCR_RST_HALF;
            lower_o <= `MCR_RST_HALF;
        end else if (re_i) begin
            upper_o <= upper_mem[idx_i];
            lower_o <= lower_mem[idx_i];
        end
    end
endmodule
`default_nettype wire

// [rtl/mcr_regs.sv]
// memory-control register set reached by control-register instructions
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.svh"
module mcr_regs
    import mcr_pkg::*;
(
    input  wire logic                  mclk_i,          // processor clock
    input  wire logic                  rst_i,           // sync reset, high
    input  wire mcr_cr_req_t           cr_req_i,        // control-register instruction
    output logic      [31:0]           cr_rdata_o,      // read answer
    output logic                       cr_rvalid_o,     // answer strobe
    input  wire mcr_err_t [1:0]        err_i,           // [1] upper, [0] lower half
    input  wire logic [31:0]           err_addr_i,      // address of current word
    input  wire logic [`MCR_SLOT_W-1:0] slot_i,         // backplane slot pins
    input  wire logic [`MCR_INT_LEVELS-1:0][`MCR_INT_W-1:0] irq_req_i, // requester sets
    input  wire logic                  mem_op_i,        // load/store issued
    output logic                       locked_cycle_o,  // issue as locked cycle
    output logic                       bus_lock_o,      // bus_lock_request bit
    output logic      [`MCR_INT_LEVELS-1:0] irq_level_o // level has a request
);
    localparam int LV = `MCR_INT_LEVELS;

    logic [7:0]               code;
    logic [`MCR_IDX_W-1:0]    idx;
    logic                     rd;
    logic                     wr;
    logic [`MCR_ENTRIES-1:0]  valid;
    logic [1:0][1:0]          err_status;
    logic [31:0]              err_addr;
    logic [1:0][`MCR_SBE_W-1:0] sbe_count;
    logic [1:0]               sbe_ovf;
    logic [LV-1:0][`MCR_INT_W-1:0] int_req;
    logic [`MCR_SLOT_W-1:0]   slot;
    logic                     slot_taken;
    logic                     lock_req;
    logic                     s1_valid;
    mcr_src_t                 s1_src;
    logic [31:0]              s1_value;
    logic [`MCR_HALF_W-1:0]   map_upper;
    logic [`MCR_HALF_W-1:0]   map_lower;
    logic                     map_re;
    logic                     we_upper;
    logic                     we_lower;
    logic                     any_fail;
    logic [31:0]              next_value;
    mcr_src_t                 next_src;
    logic [1:0]               st_rd;

    // address fields: page selects the entry, low byte the register
    assign code = cr_req_i.addr[`MCR_CODE_MSB:`MCR_CODE_LSB];
    assign idx  = cr_req_i.addr[`MCR_VPN_LSB +: `MCR_IDX_W];
    assign rd   = cr_req_i.rd & ~cr_req_i.wr;
    assign wr   = cr_req_i.wr;

    // each entry half is its own 16-bit access
    assign we_upper = wr && (code == `MCR_CODE_MAP_UPPER);
    assign we_lower = wr && (code == `MCR_CODE_MAP_LOWER);
    assign map_re   = rd && ((code == `MCR_CODE_MAP_UPPER) || (code == `MCR_CODE_MAP_LOWER));

    // entry storage; bits 31:16 of the written word are dropped
    mcr_map_mem u_map (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .idx_i      (idx),
        .we_upper_i (we_upper),
        .we_lower_i (we_lower),
        .wdata_i    (cr_req_i.wdata[`MCR_HALF_W-1:0]),
        .re_i       (map_re),
        .upper_o    (map_upper),
        .lower_o    (map_lower)
    );

    // valid bits live in flops so reset leaves every entry invalid
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            valid <= '0;
        end else if (we_upper || we_lower) begin
            valid[idx] <= 1'b1;
        end else if (wr && (code == `MCR_CODE_MAP_VALID)) begin
            valid[idx] <= 1'b0;
        end
    end
    // reads never touch valid, only the write branches above do

    // status registers clear on read; a new error in that cycle wins
    assign st_rd[1] = rd && (code == `MCR_CODE_ERRST_UPPER);
    assign st_rd[0] = rd && (code == `MCR_CODE_ERRST_LOWER);

    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            // sticky error flags of one half
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    err_status[h] <= 2'h0;
                end else begin
                    err_status[h][`MCR_ST_ECC_BIT] <= (err_status[h][`MCR_ST_ECC_BIT] & ~st_rd[h])
                                                      | err_i[h].ecc_uncorr;
                    err_status[h][`MCR_ST_ACK_BIT] <= (err_status[h][`MCR_ST_ACK_BIT] & ~st_rd[h])
                                                      | err_i[h].ack_err;
                end
            end

            // single-bit error tally, wraps after all ones
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    sbe_count[h] <= `MCR_RST_HALF;
                end else if (err_i[h].single_bit) begin
                    sbe_count[h] <= sbe_count[h] + `MCR_SBE_W'(1);
                end
            end
            assign sbe_ovf[h] = err_i[h].single_bit && (&sbe_count[h]);
        end
    endgenerate

    // capture the failing word address on either half
    assign any_fail = err_i[0].ecc_uncorr | err_i[0].ack_err
                    | err_i[1].ecc_uncorr | err_i[1].ack_err;

    // hardware capture outranks a software write in the same cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            err_addr <= `MCR_RST_WORD;
        end else if (any_fail) begin
            err_addr <= err_addr_i;
        end else if (wr && (code == `MCR_CODE_ERRADR_LOWER)) begin
            err_addr[15:0] <= cr_req_i.wdata[15:0];
        end else if (wr && (code == `MCR_CODE_ERRADR_UPPER)) begin
            err_addr[31:16] <= cr_req_i.wdata[15:0];
        end
    end

    // interrupt levels: requesters and overflow set, writing one clears
    genvar l;
    generate
        for (l = 0; l < LV; l++) begin : g_level
            logic [`MCR_INT_W-1:0] clr;
            logic [`MCR_INT_W-1:0] ovf;
            assign clr = (wr && (code == 8'(`MCR_CODE_INT_BASE + l))) ?
                         cr_req_i.wdata[`MCR_INT_W-1:0] : `MCR_RST_INT;
            if (l == `MCR_SBE_INT_LVL) begin : g_ovf
                assign ovf = `MCR_INT_W'((sbe_ovf[0] << `MCR_SBE_INT_LOWER)
                                       | (sbe_ovf[1] << `MCR_SBE_INT_UPPER));
            end else begin : g_no_ovf
                assign ovf = `MCR_RST_INT;
            end
            // set wins over a simultaneous write-one clear
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    int_req[l] <= `MCR_RST_INT;
                end else begin
                    int_req[l] <= (int_req[l] & ~clr) | irq_req_i[l] | ovf;
                end
            end
            // per-level request summary to the processor
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    irq_level_o[l] <= 1'b0;
                end else begin
                    irq_level_o[l] <= |int_req[l];
                end
            end
        end
    endgenerate

    // slot pins are sampled once, on the first edge after reset
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            slot_taken <= 1'b0;
            slot       <= '0;
        end else if (!slot_taken) begin
            slot_taken <= 1'b1;
            slot       <= slot_i;
        end
    end

    // lock request changes only on a software write
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            lock_req <= 1'b0;
        end else if (wr && (code == `MCR_CODE_LOCK)) begin
            lock_req <= cr_req_i.wdata[0];
        end
    end

    // bus cycles see the bit but never clear it
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus_lock_o     <= 1'b0;
            locked_cycle_o <= 1'b0;
        end else begin
            bus_lock_o     <= lock_req;
            locked_cycle_o <= mem_op_i & lock_req;
        end
    end

    // first read stage: pick the register value, unmapped codes read zero
    always_comb begin
        next_value = `MCR_RST_WORD;
        next_src   = MCR_SRC_REG;
        if ((code >= `MCR_CODE_INT_BASE) && (code <= `MCR_CODE_INT_LAST)) begin
            next_value = {24'h0, int_req[3'(code - `MCR_CODE_INT_BASE)]};
        end else begin
            unique case (code)
                `MCR_CODE_MAP_UPPER:    next_src   = MCR_SRC_MAP_UPPER;
                `MCR_CODE_MAP_LOWER:    next_src   = MCR_SRC_MAP_LOWER;
                `MCR_CODE_MAP_VALID:    next_value = {31'h0, valid[idx]};
                `MCR_CODE_ERRST_UPPER:  next_value = {30'h0, err_status[1]};
                `MCR_CODE_ERRST_LOWER:  next_value = {30'h0, err_status[0]};
                `MCR_CODE_ERRADR_UPPER: next_value = {16'h0, err_addr[31:16]};
                `MCR_CODE_ERRADR_LOWER: next_value = {16'h0, err_addr[15:0]};
                `MCR_CODE_SBE_UPPER:    next_value = {16'h0, sbe_count[1]};
                `MCR_CODE_SBE_LOWER:    next_value = {16'h0, sbe_count[0]};
                `MCR_CODE_SLOT:         next_value = {28'h0, slot};
                `MCR_CODE_LOCK:         next_value = {31'h0, lock_req};
                default:                next_value = `MCR_RST_WORD;
            endcase
        end
    end

    // stage one waits for the registered entry read
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s1_valid <= 1'b0;
            s1_src   <= MCR_SRC_REG;
            s1_value <= `MCR_RST_WORD;
        end else begin
            s1_valid <= rd;
            s1_src   <= next_src;
            s1_value <= next_value;
        end
    end

    // every read answers two cycles after the request, whatever the code
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cr_rvalid_o <= 1'b0;
            cr_rdata_o  <= `MCR_RST_WORD;
        end else begin
            cr_rvalid_o <= s1_valid;
            if (s1_valid) begin
                unique case (s1_src)
                    MCR_SRC_MAP_UPPER: cr_rdata_o <= {16'h0, map_upper};
                    MCR_SRC_MAP_LOWER: cr_rdata_o <= {16'h0, map_lower};
                    MCR_SRC_REG:       cr_rdata_o <= s1_value;
                    default:           cr_rdata_o <= s1_value;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [test/mcr_bus_model.sv]
// system_bus side: error events, failing address, slot pins, requesters
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.svh"
module mcr_bus_model
    import mcr_pkg::*;
#(
    parameter logic [`MCR_SLOT_W-1:0] SLOT = 4'hB // board slot
)(
    input  wire logic           mclk_i,          // clock
    input  wire logic           rst_i,           // reset
    input  wire mcr_err_t [1:0] ev_i,            // event to report
    input  wire logic [31:0]    addr_i,          // word address
    input  wire logic [6:0][7:0] irq_i,          // request to raise
    output var mcr_err_t [1:0]  err_o = '0,      // event pulses
    output var logic [31:0]     err_addr_o = '0, // failing address
    output var logic [6:0][7:0] irq_o = '0,      // requester sets
    output logic [`MCR_SLOT_W-1:0] slot_o        // slot pins
);
    // address only means something beside an event; otherwise it toggles
    always @(posedge mclk_i) begin
        err_o <= rst_i ? '0 : ev_i;
        irq_o <= rst_i ? '0 : irq_i;
        if (rst_i) err_addr_o <= '0;
        else if (|ev_i) err_addr_o <= addr_i;
        else err_addr_o <= ~err_addr_o;
    end
    assign slot_o = SLOT;
endmodule
`default_nettype wire

// [test/mcr_regs_asserts.sv]
// port-level checks on the memory-control register set
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.svh"
module mcr_regs_asserts
    import mcr_pkg::*;
(
    input  wire logic        mclk_i,         // clock
    input  wire logic        rst_i,          // reset
    input  wire mcr_cr_req_t cr_req_i,       // request
    input  wire logic [31:0] cr_rdata_o,     // answer
    input  wire logic        cr_rvalid_o,    // answer strobe
    input  wire mcr_err_t [1:0] err_i,       // error events
    input  wire logic [31:0] err_addr_i,     // failing address
    input  wire logic [`MCR_SLOT_W-1:0] slot_i, // slot pins
    input  wire logic [`MCR_INT_LEVELS-1:0][`MCR_INT_W-1:0] irq_req_i, // sets
    input  wire logic        mem_op_i,       // load/store
    input  wire logic        locked_cycle_o, // locked cycle
    input  wire logic        bus_lock_o,     // lock bit
    input  wire logic [`MCR_INT_LEVELS-1:0] irq_level_o // levels
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] code;
    logic       wr_lock;
    // code of the request on the port this cycle
    assign code    = cr_req_i.addr[7:0];
    assign wr_lock = cr_req_i.wr && code == `MCR_CODE_LOCK;

    rd_answer_a: assert property (cr_req_i.rd && !cr_req_i.wr |-> ##2 cr_rvalid_o)
        else $error("read not answered two cycles later");
    no_answer_a: assert property (!cr_req_i.rd || cr_req_i.wr |-> ##2 !cr_rvalid_o)
        else $error("answer without a read");
    rdata_hold_a: assert property (!cr_rvalid_o |-> $stable(cr_rdata_o))
        else $error("read data moved without strobe");
    valid_bit_a: assert property (cr_rvalid_o && $past(code, 2) == `MCR_CODE_MAP_VALID
        |-> cr_rdata_o[31:1] == 31'h0) else $error("valid read has extra bits");
    status_bits_a: assert property (cr_rvalid_o && $past(code[7:1], 2) == 7'h08
        |-> cr_rdata_o[31:2] == 30'h0) else $error("status read has extra bits");
    // bus_lock_o and locked_cycle_o both see the lock bit as it stood one edge earlier
    lock_cycle_a: assert property (mem_op_i |=> locked_cycle_o == bus_lock_o)
        else $error("load/store not locked");
    no_locked_a: assert property (!mem_op_i |=> !locked_cycle_o)
        else $error("locked cycle without cause");
    // a lock write shows on bus_lock_o two edges after it is taken
    lock_hold_a: assert property (bus_lock_o && !$past(wr_lock) |=> bus_lock_o)
        else $error("lock bit dropped by itself");
    lock_write_a: assert property (wr_lock |-> ##2 bus_lock_o == $past(cr_req_i.wdata[0], 2))
        else $error("lock write not stored");
    irq_level_a: assert property (|irq_req_i[2] |-> ##2 irq_level_o[2])
        else $error("request did not raise level");

    // main scenarios reached
    rd_c: cover property (cr_rvalid_o);
    lock_c: cover property (locked_cycle_o);
    ovf_c: cover property (irq_level_o[0]);
endmodule

bind mcr_regs mcr_regs_asserts i_chk (.mclk_i, .rst_i, .cr_req_i, .cr_rdata_o, .cr_rvalid_o,
    .err_i, .err_addr_i, .slot_i, .irq_req_i, .mem_op_i, .locked_cycle_o, .bus_lock_o, .irq_level_o);
`default_nettype wire

// [test/memory_control_registers_tb.sv]
// self-checking bench for the memory-control register set
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.svh"
module memory_control_registers_tb;
    import mcr_pkg::*;
    localparam logic [3:0] SLOT = 4'hB;
    logic           mclk_i = 1'b0;
    logic           rst_i = 1'b1;
    mcr_cr_req_t    req = '0;
    logic [31:0]    rdata;
    logic           rvalid;
    mcr_err_t [1:0] ev = '0;
    mcr_err_t [1:0] err;
    logic [31:0]    eaddr = '0;
    logic [31:0]    err_addr;
    logic [3:0]     slot;
    logic [6:0][7:0] irq = '0;
    logic [6:0][7:0] irq_req;
    logic           mem_op = 1'b0;
    logic           locked;
    logic           lock;
    logic [6:0]     lvl;
    logic [31:0]    expq[$];
    logic [31:0]    d;
    int             n_errors = 0;
    int             compares = 0;
    int             cyc = 0;
    int             seed = 29617;

    mcr_bus_model #(.SLOT(SLOT)) i_bus (.mclk_i, .rst_i, .ev_i(ev), .addr_i(eaddr), .irq_i(irq),
        .err_o(err), .err_addr_o(err_addr), .irq_o(irq_req), .slot_o(slot));
    mcr_regs i_dut (.mclk_i, .rst_i, .cr_req_i(req), .cr_rdata_o(rdata), .cr_rvalid_o(rvalid),
        .err_i(err), .err_addr_i(err_addr), .slot_i(slot), .irq_req_i(irq_req), .mem_op_i(mem_op),
        .locked_cycle_o(locked), .bus_lock_o(lock), .irq_level_o(lvl));

    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic final_report();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one instruction per edge; the read expectation is noted at issue
    task automatic op(input logic r, input logic [7:0] c, input logic [5:0] i, input logic [31:0] v);
        @(posedge mclk_i);
        req <= '{rd: r, wr: !r, addr: {18'h0, i, c}, wdata: r ? 32'h0 : v};
        if (r) expq.push_back(v);
    endtask

    task automatic idle(input int n);
        @(posedge mclk_i);
        req <= '0;
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic pulse(input logic [5:0] e, input logic [31:0] a);
        @(posedge mclk_i);
        ev <= e;
        eaddr <= a;
        @(posedge mclk_i);
        ev <= '0;
    endtask

    // load/store, then look at the locked flag once it has settled
    task automatic mem(input logic exp);
        @(posedge mclk_i);
        mem_op <= 1'b1;
        @(posedge mclk_i);
        mem_op <= 1'b0;
        #1 check("locked", {31'h0, locked}, {31'h0, exp});
    endtask

    // answers are matched to the oldest note
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (rvalid === 1'b1) begin
            if (expq.size() == 0) check("spare answer", 32'h1, 32'h0);
            else check("read data", rdata, expq.pop_front());
        end
        if (cyc == 80000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        op(1, `MCR_CODE_SLOT, 0, {28'h0, SLOT});
        op(1, 8'h05, 0, 32'h0);
        // halves written with a valid read between them, valid bit set and cleared
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            op(0, `MCR_CODE_MAP_UPPER, 6'(i * 9), d);
            op(1, `MCR_CODE_MAP_VALID, 6'(i * 9), 32'h1);
            op(0, `MCR_CODE_MAP_LOWER, 6'(i * 9), ~d);
            op(1, `MCR_CODE_MAP_UPPER, 6'(i * 9), {16'h0, d[15:0]});
            op(1, `MCR_CODE_MAP_LOWER, 6'(i * 9), {16'h0, ~d[15:0]});
            op(1, `MCR_CODE_MAP_VALID, 6'(i * 9), 32'h1);
            op(0, `MCR_CODE_MAP_VALID, 6'(i * 9), d);
            op(1, `MCR_CODE_MAP_VALID, 6'(i * 9), 32'h0);
        end
        idle(1);
        // uncorrectable error on the lower half, acknowledge error on the upper
        pulse(6'h02, d);
        idle(3);
        op(1, `MCR_CODE_ERRST_LOWER, 0, 32'h1);
        op(1, `MCR_CODE_ERRST_UPPER, 0, 32'h0);
        op(1, `MCR_CODE_ERRADR_LOWER, 0, {16'h0, d[15:0]});
        op(1, `MCR_CODE_ERRADR_UPPER, 0, {16'h0, d[31:16]});
        idle(1);
        pulse(6'h20, ~d);
        idle(3);
        op(1, `MCR_CODE_ERRST_UPPER, 0, 32'h2);
        op(1, `MCR_CODE_ERRADR_LOWER, 0, {16'h0, ~d[15:0]});
        // software may rewrite the low half; the upper word bits are dropped
        op(0, `MCR_CODE_ERRADR_LOWER, 0, {~d[15:0], d[15:0]});
        op(1, `MCR_CODE_ERRADR_LOWER, 0, {16'h0, d[15:0]});
        idle(1);
        // single-bit errors counted per half; lower runs through a full wrap
        repeat (3) pulse(6'h08, d);
        @(posedge mclk_i);
        ev <= 6'h01;
        repeat (65536) @(posedge mclk_i);
        ev <= '0;
        repeat (4) @(posedge mclk_i);
        check("irq level", {25'h0, lvl}, 32'h1);
        op(1, `MCR_CODE_SBE_UPPER, 0, 32'h3);
        op(1, `MCR_CODE_SBE_LOWER, 0, 32'h0);
        op(1, `MCR_CODE_INT_BASE, 0, 32'h1);
        op(0, `MCR_CODE_INT_BASE, 0, 32'h1);
        op(1, `MCR_CODE_INT_BASE, 0, 32'h0);
        idle(0);
        // requester raises level 2 bit 5, software writes one to clear it
        irq[2] <= 8'h20;
        @(posedge mclk_i);
        irq <= '0;
        idle(2);
        op(1, `MCR_CODE_INT_BASE + 8'h02, 0, 32'h20);
        op(0, `MCR_CODE_INT_BASE + 8'h02, 0, 32'h20);
        op(1, `MCR_CODE_INT_BASE + 8'h02, 0, 32'h0);
        // lock survives bus cycles until software writes zero
        op(0, `MCR_CODE_LOCK, 0, 32'h1);
        idle(1);
        mem(1'b1);
        mem(1'b1);
        op(1, `MCR_CODE_LOCK, 0, 32'h1);
        op(0, `MCR_CODE_LOCK, 0, 32'h0);
        idle(1);
        mem(1'b0);
        idle(4);
        check("pending", expq.size(), 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
